// [rtl/sdcd_pkg.sv]
// package of constants and types for the card clock divider
package sdcd_pkg;
  localparam logic [11:0] sdcd_ctrl_off = 12'h02c;
  localparam logic [11:0] sdcd_wake_off = 12'h030;
  localparam int sdcd_div_lo_pos = 8;
  localparam int sdcd_div_hi_pos = 6;
  localparam int sdcd_gen_sel_pos = 5;
  localparam int sdcd_out_on_pos = 2;
  localparam int sdcd_stable_pos = 1;
  localparam int sdcd_int_en_pos = 0;
  localparam logic [15:0] sdcd_ctrl_rst = 16'h0000;
  localparam int sdcd_settle_ns = 1000;
  localparam int sdcd_clk_mhz = 25;
  localparam logic [7:0] sdcd_settle_cyc = 8'((sdcd_settle_ns * sdcd_clk_mhz + 999) / 1000);
  localparam logic [1:0] sdcd_resp_okay = 2'h0;
  localparam logic [1:0] sdcd_resp_slverr = 2'h2;

  typedef struct packed {
    logic [9:0] div;
    logic out_on;
    logic int_en;
  } sdcd_cfg_s;

  typedef struct packed {
    logic [9:0] cnt;
    logic half;
  } sdcd_div_s;
endpackage

// [rtl/sdcd_divider.sv]
// divider turning the base clock enable into the card clock level
`timescale 1ns/10ps
module sdcd_divider
  import sdcd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [9:0] div,
  output logic card_clk
);
  sdcd_div_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (!run) begin
      s_d = '0;
    end else if (div == 10'h000) begin
      s_d.half = ~s_q.half;
      s_d.cnt = '0;
    end else if (s_q.cnt >= div - 10'h001) begin
      s_d.cnt = '0;
      s_d.half = ~s_q.half;
    end else begin
      s_d.cnt = s_q.cnt + 10'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign card_clk = s_q.half;
endmodule

// [rtl/sdcd_top.sv]
// card clock control block with axi4-lite register access
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Contract
// - divisor is ten bits, upper two then lower
// - card clock is base over two N, and base over two when N is zero
// - generator select reads zero
// - output enable drives pin while internal clock enable is set, else stopped
// - settled flag set once base stable
// - wakeup wait clears internal clock enable
module sdcd_top
  import sdcd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wakeup_wait,
  output logic card_clock_pin
);
  typedef struct packed {
    sdcd_cfg_s cfg;
    logic [9:0] div_live;
    logic [7:0] settle;
    logic stable;
    logic aw_got;
    logic [11:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic wake_s1;
    logic wake_s2;
    logic pin;
  } sdcd_state_s;

  sdcd_state_s s_q, s_d;
  logic div_clk;

  function automatic logic [15:0] ctrl_word(input sdcd_cfg_s c, input logic st);
    logic [15:0] v;
    v = 16'h0000;
    v[sdcd_div_lo_pos +: 8] = c.div[7:0];
    v[sdcd_div_hi_pos +: 2] = c.div[9:8];
    v[sdcd_gen_sel_pos] = 1'b0;
    v[sdcd_out_on_pos] = c.out_on;
    v[sdcd_stable_pos] = st;
    v[sdcd_int_en_pos] = c.int_en; // bits 4:3 stay zero
    return v;
  endfunction

  // word address match, byte lanes of the address are ignored
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
    return addr[11:2] == off[11:2];
  endfunction

  // byte lanes 0 and 1 carry the register, upper lanes are ignored
  function automatic logic [15:0] merge_lanes(input logic [15:0] old, input logic [15:0] d,
                                              input logic [1:0] strb);
    logic [15:0] m;
    m = old;
    if (strb[0]) m[7:0] = d[7:0];
    if (strb[1]) m[15:8] = d[15:8];
    return m;
  endfunction

  // writable fields out of a control word, read-only bits dropped
  function automatic sdcd_cfg_s word_cfg(input logic [15:0] w);
    sdcd_cfg_s c;
    c.div = {w[sdcd_div_hi_pos +: 2], w[sdcd_div_lo_pos +: 8]};
    c.out_on = w[sdcd_out_on_pos];
    c.int_en = w[sdcd_int_en_pos];
    return c;
  endfunction

  // settled flag never shows while the base clock is off
  function automatic logic stable_rd(input sdcd_cfg_s c, input logic st);
    return st & c.int_en;
  endfunction

  // read mux: control word, wake status, else error with zero data
  function automatic logic [33:0] read_word(input logic [11:0] addr, input sdcd_cfg_s c,
                                            input logic st, input logic wk);
    logic [33:0] r;
    r = {sdcd_resp_okay, 32'h0000_0000};
    if (reg_hit(addr, sdcd_ctrl_off)) begin
      r[31:0] = {16'h0000, ctrl_word(c, stable_rd(c, st))};
    end else if (reg_hit(addr, sdcd_wake_off)) begin
      r[31:0] = {31'h0000_0000, wk};
    end else begin
      r[33:32] = sdcd_resp_slverr;
    end
    return r;
  endfunction

  always_comb begin
    logic [15:0] nw;
    nw = 16'h0000;
    s_d = s_q;
    s_d.wake_s1 = wakeup_wait;
    s_d.wake_s2 = s_q.wake_s1;
    // settle counter after base enable
    if (!s_q.cfg.int_en) begin
      s_d.settle = '0;
      s_d.stable = 1'b0;
    end else if (s_q.settle >= sdcd_settle_cyc) begin
      s_d.stable = 1'b1;
    end else begin
      s_d.settle = s_q.settle + 8'h01;
    end
    // write channels taken in either order, one slot each
    if (s_axi_awvalid && !s_q.aw_got) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_got) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    // both halves held: apply the write and raise the response
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = sdcd_resp_okay;
      if (reg_hit(s_q.awaddr, sdcd_ctrl_off)) begin
        nw = merge_lanes(ctrl_word(s_q.cfg, 1'b0), s_q.wdata[15:0], s_q.wstrb[1:0]);
        s_d.cfg = word_cfg(nw);
      end else if (!reg_hit(s_q.awaddr, sdcd_wake_off)) begin
        s_d.bresp = sdcd_resp_slverr;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // hardware clear wins over a software set
    if (s_q.wake_s2) begin
      s_d.cfg.int_en = 1'b0;
    end
    // read answered one cycle after it is taken, held until rready
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      {s_d.rresp, s_d.rdata} = read_word(s_axi_araddr, s_q.cfg, s_q.stable, s_q.wake_s2);
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // divisor reaches the divider only while the card clock is stopped
    if (!s_q.cfg.out_on) begin
      s_d.div_live = s_q.cfg.div;
    end
    // pin is registered so the card never sees a combinational glitch
    s_d.pin = s_q.cfg.out_on & div_clk;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // divider stops when output is off
  sdcd_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(s_q.cfg.out_on & s_q.cfg.int_en),
    .div(s_q.div_live),
    .card_clk(div_clk)
  );

  assign s_axi_awready = !s_q.aw_got;
  assign s_axi_wready = !s_q.w_got;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign card_clock_pin = s_q.pin;
endmodule

// [dv/sdcd_card_model.sv]
// card side model timing the received clock
`timescale 1ns/10ps
module sdcd_card_model (
  input wire logic aclk,
  input wire logic clk_in,
  output int period,
  output int edges
);
  int cnt;
  logic last;
  always @(posedge aclk) begin
    cnt <= cnt + 1;
    last <= clk_in;
    if (clk_in && !last) begin
      period <= cnt + 1;
      cnt <= 0;
      edges <= edges + 1;
    end
  end
endmodule

// [dv/sdcd_chk.sv]
// assertions on the card clock block ports
`timescale 1ns/10ps
module sdcd_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wakeup_wait,
  input wire logic card_clock_pin,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence woken; wakeup_wait [*6]; endsequence
  a_gen_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[5]) else $error("gen");
  a_rsvd_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[4:3]) else $error("rsvd");
  a_stable_en: assert property (s_axi_rvalid && s_axi_rdata[1] |-> s_axi_rdata[0])
    else $error("stable");
  a_wake_stop: assert property (woken |=> !card_clock_pin) else $error("wake");
  a_aw_free: assert property ($rose(s_axi_bvalid) |-> s_axi_awready) else $error("aw");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar");
  a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b");
  a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("r");
endmodule
bind sdcd_top sdcd_chk sdcd_chk_inst (.*);

// [dv/sdcd_top_test.sv]
// self-checking bench for the card clock block
`timescale 1ns/10ps
module sdcd_top_test;
  import sdcd_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1, wakeup_wait = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, card_clock_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [9:0] nl [5] = '{10'h0, 10'h1, 10'h2, 10'h255, 10'h3ff};
  int failures = 0, comparisons = 0, cyc = 0, period, edges, e0;
  sdcd_top sdcd_top_inst (.*);
  sdcd_card_model sdcd_card_model_inst (.aclk, .clk_in(card_clock_pin), .period, .edges);
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 30000) begin
      failures++;
      summarize();
    end
  end
  task automatic chk(string s, logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // aw and w offered together, both readies rise together when the slot is free
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    logic t;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
    do begin
      @(negedge aclk);
      t = w ? s_axi_awready && s_axi_wready : s_axi_arready;
      @(posedge aclk);
    end while (!t);
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
    do begin
      @(negedge aclk);
      t = w ? s_axi_bvalid : s_axi_rvalid;
      rv = s_axi_rdata;
      rr = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
    end while (!t);
  endtask
  task automatic t_settle;
    bus(1'h0, sdcd_ctrl_off, 32'h0);
    chk("reset", 32'h0, rv);
    chk("rresp", sdcd_resp_okay, rr);
    bus(1'h1, sdcd_ctrl_off, 32'h1);
    chk("bresp", sdcd_resp_okay, rr);
    bus(1'h0, sdcd_ctrl_off, 32'h0);
    chk("early", 32'h1, rv);
    repeat (sdcd_settle_cyc + 4) @(posedge aclk);
    bus(1'h0, sdcd_ctrl_off, 32'h0);
    chk("settled", 32'h3, rv);
  endtask
  task automatic t_div(logic [9:0] n);
    logic [31:0] c;
    c = {16'h0, n[7:0], n[9:8], 6'h01};
    bus(1'h1, sdcd_ctrl_off, c);
    bus(1'h1, sdcd_ctrl_off, c | 32'h4);
    repeat (6 * n + 12) @(posedge aclk);
    bus(1'h0, sdcd_ctrl_off, 32'h0);
    chk("ctrl", c | 32'h6, rv);
    bus(1'h1, sdcd_ctrl_off, c);
    @(negedge aclk);
    chk("period", (n == 0) ? 2 : 2 * n, period);
    e0 = edges;
    repeat (2 * n + 8) @(negedge aclk);
    chk("stopped", e0, edges);
    @(posedge aclk);
  endtask
  task automatic t_wake;
    bus(1'h1, sdcd_ctrl_off, 32'hffc5);
    wakeup_wait <= 1'h1;
    repeat (8) @(posedge aclk);
    bus(1'h0, sdcd_ctrl_off, 32'h0);
    chk("wake", 32'hffc4, rv);
    bus(1'h0, sdcd_wake_off, 32'h0);
    chk("wstat", 32'h1, rv);
    wakeup_wait <= 1'h0;
    bus(1'h0, 12'h100, 32'h0);
    chk("unmapped", 32'h0, rv);
    chk("uresp", sdcd_resp_slverr, rr);
  endtask
  task automatic summarize;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_settle();
    foreach (nl[i]) t_div(nl[i]);
    t_wake();
    summarize();
  end
endmodule
